// ==== design/stt_status_group.sv ====
// operation status group: edge qualifiers, latched events, enable mask
`timescale 1ns/100ps
`default_nettype none
module stt_status_group
    import stt_pkg::*;
(
    input  wire logic              clock_i,     // system clock
    input  wire logic              rst_i,       // async reset, high
    input  wire logic [OPER_W-1:0] cond_i,      // condition bits
    input  wire logic              rise_we_i,   // write rising qualifier
    input  wire logic              fall_we_i,   // write falling qualifier
    input  wire logic              enable_we_i, // write enable mask
    input  wire logic              event_clr_i, // event read, clear
    input  wire logic [OPER_W-1:0] wdata_i,     // write data
    output logic [OPER_W-1:0]      rise_o,      // rising qualifier
    output logic [OPER_W-1:0]      fall_o,      // falling qualifier
    output logic [OPER_W-1:0]      event_o,     // latched events
    output logic [OPER_W-1:0]      enable_o,    // enable mask
    output logic                   summary_o    // enabled event summary
);
    logic [OPER_W-1:0] prev_r;
    logic              primed_r;
    logic [OPER_W-1:0] qual;

    // no edge is qualified until prev_r holds a real sample, so reset makes no event
    assign qual = ((cond_i & ~prev_r & rise_o) | (~cond_i & prev_r & fall_o))
                & {OPER_W{primed_r}};
    assign summary_o = |(event_o & enable_o);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r   <= EVENT_RESET;
            primed_r <= 1'b0;
        end else begin
            prev_r   <= cond_i;
            primed_r <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rise_o   <= RISE_RESET;
            fall_o   <= FALL_RESET;
            enable_o <= ENABLE_RESET;
        end else begin
            if (rise_we_i) begin
                rise_o <= wdata_i & OPER_USED_MASK;
            end
            if (fall_we_i) begin
                fall_o <= wdata_i & OPER_USED_MASK;
            end
            if (enable_we_i) begin
                enable_o <= wdata_i & OPER_USED_MASK;
            end
        end
    end

    // a new edge in the clearing cycle survives the clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            event_o <= EVENT_RESET;
        end else begin
            event_o <= (event_o & ~{OPER_W{event_clr_i}}) | qual;
        end
    end
endmodule // stt_status_group
`default_nettype wire

// ==== design/stt_trigger_status.sv ====
// transient trigger, levels, over-voltage trip and operation status
//
// What this block does
// - immediate trigger fires regardless of source
// - accepted trigger in step mode applies triggered voltage and current
// - finished trigger clears awaiting-trigger bit
// - only remote-command source accepted and reported
// - common trigger and bus trigger act alike
// - immediate and triggered levels, 0 to 102%
// - hold-level or step mode, reset hold-level
// - overvoltage disables output, sets trip flag
// - trip holds until protection-clear command
// - condition bits follow state, not latched
// - qualifiers pass rising, falling, both or none
// - event latches first edge; read-only register
// - enable mask gates events into summary
// - registers use binary-weighted bit values
// - group summary drives status byte bit 7
// - condition bits: voltage, current regulated, off
// - bit 4 awaiting trigger; others read zero
// - arm moves idle to waiting for trigger
// - abort returns to idle; also at reset
// - continuous arming re-arms after each trigger
// - trigger during arming ignored
`timescale 1ns/100ps
`default_nettype none
module stt_trigger_status
    import stt_pkg::*;
#(
    parameter int ARM_DELAY = ARM_CYCLES  // cycles from arm to ready
) (
    input  wire logic             clock_i,          // system clock
    input  wire logic             rst_i,            // async reset, high
    input  wire stt_cmd_type      cmd_i,            // command from controller
    input  wire logic             bus_trigger_i,    // group execute trigger pulse
    input  wire logic             volt_regulated_i, // regulating on voltage
    input  wire logic             curr_regulated_i, // regulating on current
    input  wire logic [LVL_W-1:0] measured_volt_i,  // measured output voltage
    output stt_rsp_type           rsp_o,            // command answer
    output logic [LVL_W-1:0]      volt_setpoint_o,  // applied voltage level
    output logic [LVL_W-1:0]      curr_setpoint_o,  // applied current level
    output logic                  output_on_o,      // output stage enabled
    output logic                  overvolt_trip_flag_o,  // trip active
    output logic                  awaiting_trigger_flag_o, // ready for trigger
    output logic [7:0]            status_byte_part_o     // status byte share
);
    stt_tstate_type    tstate_r;
    logic [ARM_CNT_W-1:0] arm_cnt_r;
    logic [LVL_W-1:0]  volt_imm_r;
    logic [LVL_W-1:0]  volt_trg_r;
    logic [LVL_W-1:0]  curr_imm_r;
    logic [LVL_W-1:0]  curr_trg_r;
    logic [LVL_W-1:0]  over_limit_r;
    stt_vmode_type     vmode_r;
    logic              cont_r;
    logic              out_en_r;
    logic              trip_r;
    logic              trip_nxt;
    logic [OPER_W-1:0] cond_r;
    stt_rsp_type       rsp_nxt;

    logic [OPER_W-1:0] rise_q;
    logic [OPER_W-1:0] fall_q;
    logic [OPER_W-1:0] event_q;
    logic [OPER_W-1:0] enable_q;
    logic              summary;

    logic is_op;
    logic trig_req;
    logic trig_take;
    logic wr_ok;
    logic set_volt_imm;
    logic set_volt_trg;
    logic set_curr_imm;
    logic set_curr_trg;
    logic set_mode;
    logic set_limit;
    logic set_cont;
    logic set_output;

    assign is_op = cmd_i.valid;

    // source is fixed to remote command, so common and bus triggers always qualify
    assign trig_req = (is_op && cmd_i.op == OP_TRIGGER_IMM)
                    || (is_op && cmd_i.op == OP_TRIGGER_COMMON)
                    || bus_trigger_i;
    assign trig_take = trig_req && (tstate_r == TS_WAITING);

    // command decode and answer
    always_comb begin
        rsp_nxt       = '0;
        rsp_nxt.valid = is_op;
        wr_ok         = 1'b0;
        case (cmd_i.op)
            OP_ARM, OP_ABORT, OP_PROT_CLEAR: begin
                rsp_nxt.data = '0;
            end
            OP_TRIGGER_IMM, OP_TRIGGER_COMMON: begin
                rsp_nxt.error = ~trig_take;
            end
            OP_SET_SOURCE: begin
                rsp_nxt.error = (cmd_i.data != SOURCE_BUS_CODE);
            end
            OP_GET_SOURCE: begin
                rsp_nxt.data = SOURCE_BUS_CODE;
            end
            OP_SET_VOLT_IMM, OP_SET_VOLT_TRG: begin
                wr_ok = (cmd_i.data <= VOLT_MAX);
                rsp_nxt.error = ~wr_ok;
            end
            OP_SET_CURR_IMM, OP_SET_CURR_TRG: begin
                wr_ok = (cmd_i.data <= CURR_MAX);
                rsp_nxt.error = ~wr_ok;
            end
            OP_SET_LIMIT: begin
                wr_ok = (cmd_i.data <= OVER_MAX);
                rsp_nxt.error = ~wr_ok;
            end
            OP_SET_MODE, OP_SET_CONT, OP_SET_OUTPUT: begin
                wr_ok = (cmd_i.data <= 16'h0001);
                rsp_nxt.error = ~wr_ok;
            end
            OP_GET_VOLT_IMM: begin
                rsp_nxt.data = volt_imm_r;
            end
            OP_GET_VOLT_TRG: begin
                rsp_nxt.data = volt_trg_r;
            end
            OP_GET_CURR_IMM: begin
                rsp_nxt.data = curr_imm_r;
            end
            OP_GET_CURR_TRG: begin
                rsp_nxt.data = curr_trg_r;
            end
            OP_GET_MODE: begin
                rsp_nxt.data = {15'h0000, vmode_r};
            end
            OP_GET_LIMIT: begin
                rsp_nxt.data = over_limit_r;
            end
            OP_GET_CONT: begin
                rsp_nxt.data = {15'h0000, cont_r};
            end
            OP_GET_OUTPUT: begin
                rsp_nxt.data = {15'h0000, out_en_r};
            end
            OP_GET_COND: begin
                rsp_nxt.data = cond_r;
            end
            OP_GET_RISE: begin
                rsp_nxt.data = rise_q;
            end
            OP_GET_FALL: begin
                rsp_nxt.data = fall_q;
            end
            OP_GET_EVENT: begin
                rsp_nxt.data = event_q;
            end
            OP_GET_ENABLE: begin
                rsp_nxt.data = enable_q;
            end
            OP_SET_RISE, OP_SET_FALL, OP_SET_ENABLE: begin
                rsp_nxt.data = '0;
            end
            default: begin
                rsp_nxt.error = 1'b1;
            end
        endcase
        if (!is_op) begin
            rsp_nxt = '0;
        end
    end

    assign set_volt_imm = is_op && wr_ok && cmd_i.op == OP_SET_VOLT_IMM;
    assign set_volt_trg = is_op && wr_ok && cmd_i.op == OP_SET_VOLT_TRG;
    assign set_curr_imm = is_op && wr_ok && cmd_i.op == OP_SET_CURR_IMM;
    assign set_curr_trg = is_op && wr_ok && cmd_i.op == OP_SET_CURR_TRG;
    assign set_mode     = is_op && wr_ok && cmd_i.op == OP_SET_MODE;
    assign set_limit    = is_op && wr_ok && cmd_i.op == OP_SET_LIMIT;
    assign set_cont     = is_op && wr_ok && cmd_i.op == OP_SET_CONT;
    assign set_output   = is_op && wr_ok && cmd_i.op == OP_SET_OUTPUT;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o <= rsp_nxt;
        end
    end

    // trigger sequencer; reset lands in idle, as an abort would
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tstate_r  <= TS_IDLE;
            arm_cnt_r <= '0;
        end else if (is_op && cmd_i.op == OP_ABORT) begin
            tstate_r  <= TS_IDLE;
            arm_cnt_r <= '0;
        end else begin
            case (tstate_r)
                TS_IDLE: begin
                    // continuous arming restarts even after an abort
                    if ((is_op && cmd_i.op == OP_ARM) || cont_r) begin
                        tstate_r  <= TS_ARMING;
                        arm_cnt_r <= ARM_CNT_W'(ARM_DELAY - 1);
                    end
                end
                TS_ARMING: begin
                    if (arm_cnt_r == '0) begin
                        tstate_r <= TS_WAITING;
                    end else begin
                        arm_cnt_r <= arm_cnt_r - 1'b1;
                    end
                end
                TS_WAITING: begin
                    if (trig_take) begin
                        tstate_r <= TS_IDLE;
                    end
                end
                default: begin
                    tstate_r <= TS_IDLE;
                end
            endcase
        end
    end

    // levels; the triggered level reaches the output only on a step trigger
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            volt_imm_r <= LEVEL_ZERO;
            volt_trg_r <= LEVEL_ZERO;
            curr_imm_r <= LEVEL_ZERO;
            curr_trg_r <= LEVEL_ZERO;
        end else begin
            if (trig_take && vmode_r == VMODE_STEP) begin
                volt_imm_r <= volt_trg_r;
                curr_imm_r <= curr_trg_r;
            end else begin
                if (set_volt_imm) begin
                    volt_imm_r <= cmd_i.data;
                end
                if (set_curr_imm) begin
                    curr_imm_r <= cmd_i.data;
                end
            end
            if (set_volt_trg) begin
                volt_trg_r <= cmd_i.data;
            end
            if (set_curr_trg) begin
                curr_trg_r <= cmd_i.data;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            volt_setpoint_o <= LEVEL_ZERO;
            curr_setpoint_o <= LEVEL_ZERO;
        end else begin
            volt_setpoint_o <= volt_imm_r;
            curr_setpoint_o <= curr_imm_r;
        end
    end

    // settings
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            vmode_r      <= VMODE_HOLD_LEVEL;
            cont_r       <= CONT_RESET;
            out_en_r     <= OUT_EN_RESET;
            over_limit_r <= OVER_LIMIT_RESET;
        end else begin
            if (set_mode) begin
                vmode_r <= stt_vmode_type'(cmd_i.data[0]);
            end
            if (set_cont) begin
                cont_r <= cmd_i.data[0];
            end
            if (set_output) begin
                out_en_r <= cmd_i.data[0];
            end
            if (set_limit) begin
                over_limit_r <= cmd_i.data;
            end
        end
    end

    // a clear while the voltage is still high does not release the trip
    always_comb begin
        trip_nxt = trip_r;
        if (is_op && cmd_i.op == OP_PROT_CLEAR) begin
            trip_nxt = 1'b0;
        end
        if (out_en_r && measured_volt_i > over_limit_r) begin
            trip_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            trip_r      <= 1'b0;
            output_on_o <= 1'b0;
        end else begin
            trip_r      <= trip_nxt;
            output_on_o <= out_en_r && !trip_nxt;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            overvolt_trip_flag_o    <= 1'b0;
            awaiting_trigger_flag_o <= 1'b0;
        end else begin
            overvolt_trip_flag_o    <= trip_nxt;
            awaiting_trigger_flag_o <= (tstate_r == TS_WAITING) && !trig_take;
        end
    end

    // condition follows state every cycle; unused bits stay zero
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            // off bit resets to its idle level: no false edge after reset
            cond_r               <= '0;
            cond_r[COND_OFF_BIT] <= !OUT_EN_RESET;
        end else begin
            cond_r                <= '0;
            cond_r[COND_VREG_BIT] <= volt_regulated_i;
            cond_r[COND_CREG_BIT] <= curr_regulated_i;
            cond_r[COND_OFF_BIT]  <= !out_en_r;
            cond_r[COND_WAIT_BIT] <= (tstate_r == TS_WAITING) && !trig_take;
        end
    end

    stt_status_group u_group (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .cond_i      (cond_r),
        .rise_we_i   (is_op && cmd_i.op == OP_SET_RISE),
        .fall_we_i   (is_op && cmd_i.op == OP_SET_FALL),
        .enable_we_i (is_op && cmd_i.op == OP_SET_ENABLE),
        .event_clr_i (is_op && cmd_i.op == OP_GET_EVENT),
        .wdata_i     (cmd_i.data),
        .rise_o      (rise_q),
        .fall_o      (fall_q),
        .event_o     (event_q),
        .enable_o    (enable_q),
        .summary_o   (summary)
    );

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            status_byte_part_o <= 8'h00;
        end else begin
            status_byte_part_o               <= 8'h00;
            status_byte_part_o[STB_OPER_BIT] <= summary;
        end
    end
endmodule // stt_trigger_status
`default_nettype wire

// ==== include/stt_pkg.sv ====
// shared constants and types for the status and transient trigger block
`default_nettype none
package stt_pkg;
    localparam int CLK_MHZ      = 50;
    localparam int ARM_TIME_US  = 2000;
    localparam int ARM_CYCLES   = ARM_TIME_US * CLK_MHZ;
    localparam int ARM_CNT_W    = 20;
    localparam int LVL_W        = 16;
    localparam int OPER_W       = 16;
    // level codes: full rating is this code, levels scale linearly
    localparam int RATED_CODE   = 32'h0000_2710;
    localparam int VOLT_MAX_PCT = 102;
    localparam int CURR_MAX_PCT = 102;
    localparam int OVER_MAX_PCT = 120;

    localparam logic [LVL_W-1:0] VOLT_MAX   = LVL_W'(RATED_CODE * VOLT_MAX_PCT / 100);
    localparam logic [LVL_W-1:0] CURR_MAX   = LVL_W'(RATED_CODE * CURR_MAX_PCT / 100);
    localparam logic [LVL_W-1:0] OVER_MAX   = LVL_W'(RATED_CODE * OVER_MAX_PCT / 100);
    localparam logic [LVL_W-1:0] LEVEL_ZERO = 16'h0000;
    localparam logic [LVL_W-1:0] OVER_LIMIT_RESET = OVER_MAX;
    localparam logic             CONT_RESET   = 1'b1;
    localparam logic             OUT_EN_RESET = 1'b0;
    localparam logic [15:0]      SOURCE_BUS_CODE = 16'h0000;

    localparam int COND_VREG_BIT = 0;
    localparam int COND_CREG_BIT = 1;
    localparam int COND_OFF_BIT  = 2;
    localparam int COND_WAIT_BIT = 4;
    localparam int STB_OPER_BIT  = 7;
    localparam logic [OPER_W-1:0] OPER_USED_MASK = 16'h0017;
    localparam logic [OPER_W-1:0] RISE_RESET     = 16'h0017;
    localparam logic [OPER_W-1:0] FALL_RESET     = 16'h0000;
    localparam logic [OPER_W-1:0] ENABLE_RESET   = 16'h0000;
    localparam logic [OPER_W-1:0] EVENT_RESET    = 16'h0000;

    typedef enum logic [4:0] {
        OP_ARM, OP_ABORT, OP_TRIGGER_IMM, OP_TRIGGER_COMMON,
        OP_SET_SOURCE, OP_GET_SOURCE,
        OP_SET_VOLT_IMM, OP_GET_VOLT_IMM, OP_SET_VOLT_TRG, OP_GET_VOLT_TRG,
        OP_SET_CURR_IMM, OP_GET_CURR_IMM, OP_SET_CURR_TRG, OP_GET_CURR_TRG,
        OP_SET_MODE, OP_GET_MODE, OP_SET_LIMIT, OP_GET_LIMIT, OP_PROT_CLEAR,
        OP_SET_CONT, OP_GET_CONT, OP_SET_OUTPUT, OP_GET_OUTPUT,
        OP_GET_COND, OP_SET_RISE, OP_GET_RISE, OP_SET_FALL, OP_GET_FALL,
        OP_GET_EVENT, OP_SET_ENABLE, OP_GET_ENABLE
    } stt_op_type;

    typedef enum logic {
        VMODE_HOLD_LEVEL,
        VMODE_STEP
    } stt_vmode_type;

    typedef enum logic [1:0] {
        TS_IDLE,
        TS_ARMING,
        TS_WAITING
    } stt_tstate_type;

    typedef struct packed {
        logic        valid;
        stt_op_type  op;
        logic [15:0] data;
    } stt_cmd_type;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [15:0] data;
    } stt_rsp_type;
endpackage
`default_nettype wire

// ==== verification/stt_checker_sva.sv ====
// concurrent checks on the trigger and status block ports
`timescale 1ns/100ps
`default_nettype none
module stt_checker
    import stt_pkg::*;
#(
    parameter int ARM_DELAY = 4  // arming cycles
) (
    input wire logic             clock_i,                 // clock
    input wire logic             rst_i,                   // reset
    input wire stt_cmd_type      cmd_i,                   // command
    input wire logic [LVL_W-1:0] measured_volt_i,         // measured volts
    input wire stt_rsp_type      rsp_o,                   // answer
    input wire logic             output_on_o,             // output on
    input wire logic             overvolt_trip_flag_o,    // trip
    input wire logic             awaiting_trigger_flag_o, // armed
    input wire logic [7:0]       status_byte_part_o       // status share
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    chk_rsp_timing: assert property (
        rsp_o.valid == $past(cmd_i.valid))
        else $error("answer valid not one cycle after command");
    chk_status_low_zero: assert property (
        status_byte_part_o[6:0] == 7'h00)
        else $error("status byte bits other than 7 not zero");
    chk_trip_output_off: assert property (
        overvolt_trip_flag_o |-> !output_on_o)
        else $error("output on while tripped");
    chk_trip_sets_now: assert property (
        measured_volt_i > OVER_MAX && output_on_o |=> overvolt_trip_flag_o && !output_on_o)
        else $error("overvoltage did not trip");
    chk_trip_holds_on: assert property (
        overvolt_trip_flag_o && !(cmd_i.valid && cmd_i.op == OP_PROT_CLEAR)
        |=> overvolt_trip_flag_o)
        else $error("trip released without clear");
    chk_abort_clears_wait: assert property (
        cmd_i.valid && cmd_i.op == OP_ABORT |=> ##1 !awaiting_trigger_flag_o)
        else $error("abort left trigger armed");
    chk_trig_clears_wait: assert property (
        awaiting_trigger_flag_o && cmd_i.valid && cmd_i.op == OP_TRIGGER_IMM
        |=> !awaiting_trigger_flag_o)
        else $error("trigger left waiting flag set");
    chk_arm_takes_time: assert property (
        $rose(awaiting_trigger_flag_o) |-> $past(awaiting_trigger_flag_o, ARM_DELAY) == 1'b0)
        else $error("armed sooner than arming time");
endmodule // stt_checker
`default_nettype wire

// ==== verification/stt_ctrl_model.sv ====
// remote controller model: sends commands and bus triggers
`timescale 1ns/100ps
`default_nettype none
module stt_ctrl_model
    import stt_pkg::*;
(
    input  wire logic        clock_i, // clock
    input  wire stt_rsp_type rsp_i,   // device answer
    output var stt_cmd_type  cmd_o,   // command
    output var logic         get_o    // bus trigger pulse
);
    initial begin
        cmd_o = '0;
        get_o = 1'b0;
    end
    // answer is caught in whichever cycle it stands, up to three
    task automatic send(input stt_op_type op, input logic [15:0] d, output stt_rsp_type r);
        int k;
        @(negedge clock_i);
        cmd_o = {1'b1, op, d};
        @(negedge clock_i);
        cmd_o = {1'b0, op, ~d};  // idle data must not look like the last word
        r = '0;
        for (k = 0; k < 3 && r.valid !== 1'b1; k++) begin
            if (rsp_i.valid === 1'b1) r = rsp_i;
            else @(negedge clock_i);
        end
    endtask
    task automatic bus_trig();
        @(negedge clock_i);
        get_o = 1'b1;
        @(negedge clock_i);
        get_o = 1'b0;
    endtask
endmodule // stt_ctrl_model
`default_nettype wire

// ==== verification/stt_trigger_status_bench.sv ====
// self-checking bench for the trigger and status block
`timescale 1ns/100ps
`default_nettype none
bind stt_trigger_status stt_checker #(.ARM_DELAY(ARM_DELAY)) chk_u (.clock_i, .rst_i,
    .cmd_i, .measured_volt_i, .rsp_o, .output_on_o, .overvolt_trip_flag_o,
    .awaiting_trigger_flag_o, .status_byte_part_o);
module stt_trigger_status_bench;
    import stt_pkg::*;
    localparam int ARM_D = 4;  // short arming keeps the run brief
    logic             clock_i;
    logic             rst_i;
    logic             vreg;
    logic             creg;
    logic             get;
    logic [LVL_W-1:0] meas;
    logic [LVL_W-1:0] vset;
    logic [LVL_W-1:0] cset;
    stt_cmd_type      cmd;
    stt_rsp_type      rsp;
    stt_rsp_type      r;
    logic             on;
    logic             trip;
    logic             wait_f;
    logic [7:0]       sb;
    int               n_fail = 0;
    int               n_checks = 0;

    stt_trigger_status #(.ARM_DELAY(ARM_D)) dut_u (.clock_i, .rst_i, .cmd_i(cmd),
        .bus_trigger_i(get), .volt_regulated_i(vreg), .curr_regulated_i(creg),
        .measured_volt_i(meas), .rsp_o(rsp), .volt_setpoint_o(vset), .curr_setpoint_o(cset),
        .output_on_o(on), .overvolt_trip_flag_o(trip), .awaiting_trigger_flag_o(wait_f),
        .status_byte_part_o(sb));
    stt_ctrl_model ctrl_u (.clock_i, .rsp_i(rsp), .cmd_o(cmd), .get_o(get));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_op(input stt_op_type op, input logic [15:0] d);
        ctrl_u.send(op, d, r);
        check(16'(r.valid), 16'h0001);
    endtask
    task automatic wait_armed();
        int k;
        for (k = 0; k < 20 && wait_f !== 1'b1; k++) @(negedge clock_i);
        if (wait_f !== 1'b1) begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic t_defaults();
        stt_op_type ops[8] = '{OP_GET_VOLT_IMM, OP_GET_MODE, OP_GET_LIMIT, OP_GET_CONT,
            OP_GET_RISE, OP_GET_FALL, OP_GET_ENABLE, OP_GET_SOURCE};
        logic [15:0] exp[8] = '{16'h0000, 16'h0000, OVER_MAX, 16'h0001,
            16'h0017, 16'h0000, 16'h0000, 16'h0000};
        foreach (ops[i]) begin
            do_op(ops[i], 16'h0000);
            check(r.data, exp[i]);
        end
        // only the waiting bit has risen since reset; the off bit is no event
        do_op(OP_GET_EVENT, 16'h0000);
        check(r.data, 16'h0010);
        do_op(OP_SET_SOURCE, 16'h0001);
        check(16'(r.error), 16'h0001);
        do_op(OP_SET_VOLT_IMM, VOLT_MAX + 16'h0001);
        check(16'(r.error), 16'h0001);
        do_op(OP_SET_LIMIT, OVER_MAX + 16'h0001);
        check(16'(r.error), 16'h0001);
    endtask
    task automatic t_step();
        do_op(OP_SET_MODE, 16'h0001);
        do_op(OP_SET_CURR_TRG, 16'h0BB8);
        do_op(OP_SET_VOLT_TRG, 16'h1388);
        do_op(OP_GET_VOLT_TRG, 16'h0000);
        check(r.data, 16'h1388);
        wait_armed();
        do_op(OP_TRIGGER_IMM, 16'h0000);
        check(16'(r.error), 16'h0000);
        check(16'(wait_f), 16'h0000);
        repeat (2) @(negedge clock_i);
        check(vset, 16'h1388);
        check(cset, 16'h0BB8);
        do_op(OP_SET_VOLT_TRG, 16'h1770);
        wait_armed();
        ctrl_u.bus_trig();
        repeat (3) @(negedge clock_i);
        check(vset, 16'h1770);
        do_op(OP_SET_VOLT_TRG, 16'h1B58);
        wait_armed();
        do_op(OP_TRIGGER_COMMON, 16'h0000);
        repeat (2) @(negedge clock_i);
        check(vset, 16'h1B58);
        do_op(OP_SET_MODE, 16'h0000);
        do_op(OP_SET_VOLT_TRG, 16'h1F40);
        wait_armed();
        do_op(OP_TRIGGER_IMM, 16'h0000);
        repeat (2) @(negedge clock_i);
        check(vset, 16'h1B58);
    endtask
    task automatic t_arm();
        do_op(OP_SET_CONT, 16'h0000);
        do_op(OP_ABORT, 16'h0000);
        repeat (8) @(negedge clock_i);
        check(16'(wait_f), 16'h0000);
        do_op(OP_TRIGGER_IMM, 16'h0000);
        check(16'(r.error), 16'h0001);
        do_op(OP_ARM, 16'h0000);
        do_op(OP_TRIGGER_IMM, 16'h0000);
        check(16'(r.error), 16'h0001);
        wait_armed();
        do_op(OP_TRIGGER_IMM, 16'h0000);
        check(16'(r.error), 16'h0000);
    endtask
    task automatic t_status();
        do_op(OP_SET_RISE, 16'h0000);
        do_op(OP_SET_FALL, 16'h0010);
        do_op(OP_SET_ENABLE, 16'h0010);
        do_op(OP_GET_EVENT, 16'h0000);
        do_op(OP_ARM, 16'h0000);
        wait_armed();
        do_op(OP_GET_EVENT, 16'h0000);
        check(r.data, 16'h0000);
        do_op(OP_TRIGGER_IMM, 16'h0000);
        repeat (4) @(negedge clock_i);
        check({8'h00, sb}, 16'h0080);
        do_op(OP_GET_EVENT, 16'h0000);
        check(r.data, 16'h0010);
        do_op(OP_GET_EVENT, 16'h0000);
        check(r.data, 16'h0000);
        vreg = 1'b1;
        repeat (3) @(negedge clock_i);
        do_op(OP_GET_COND, 16'h0000);
        check(r.data, 16'h0005);
        vreg = 1'b0;
        creg = 1'b1;
        repeat (3) @(negedge clock_i);
        do_op(OP_GET_COND, 16'h0000);
        check(r.data, 16'h0006);
    endtask
    task automatic t_trip();
        do_op(OP_SET_LIMIT, 16'h1388);
        do_op(OP_SET_OUTPUT, 16'h0001);
        repeat (2) @(negedge clock_i);
        check(16'(on), 16'h0001);
        meas = OVER_MAX + 16'h0001;
        repeat (2) @(negedge clock_i);
        check(16'(trip), 16'h0001);
        check(16'(on), 16'h0000);
        do_op(OP_PROT_CLEAR, 16'h0000);
        repeat (2) @(negedge clock_i);
        check(16'(trip), 16'h0001);
        meas = 16'h1388;  // equal to limit is not over it
        repeat (3) @(negedge clock_i);
        check(16'(trip), 16'h0001);
        do_op(OP_PROT_CLEAR, 16'h0000);
        repeat (2) @(negedge clock_i);
        check(16'(trip), 16'h0000);
        check(16'(on), 16'h0001);
    endtask

    initial begin
        rst_i = 1'b1;
        vreg = 1'b0;
        creg = 1'b0;
        meas = '0;
        repeat (3) @(negedge clock_i);
        rst_i = 1'b0;
        t_defaults();
        t_step();
        t_arm();
        t_status();
        t_trip();
        conclude();
    end
endmodule // stt_trigger_status_bench
`default_nettype wire
